// file: core/snm_array.sv
`timescale 1ns/1ns
module snm_array #(
	parameter int DEPTH = snm_pkg::MEM_DEPTH
) (
	input wire logic clock_i,
	input wire snm_pkg::snm_wr_t wr_i,
	input wire logic [snm_pkg::ADDR_W-1:0] rd_addr_i,
	output logic [snm_pkg::DATA_W-1:0] rd_data_o
);

	// Nonvolatile contents: no reset on purpose
	logic [snm_pkg::DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge clock_i) begin
		if (wr_i.en) begin
			mem[wr_i.addr] <= wr_i.data;
		end
	end

	assign rd_data_o = mem[rd_addr_i];

endmodule

// file: core/snm_pkg.sv
package snm_pkg;

	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 8192;
	localparam int SCK_MAX_HZ = 16000000;

	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_MEM_READ = 8'h03;
	localparam logic [7:0] OP_MEM_WRITE = 8'h02;

	localparam int STAT_LOCK_BIT = 7;
	localparam int STAT_BP_HI = 3;
	localparam int STAT_BP_LO = 2;
	localparam int STAT_WEL_BIT = 1;

	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;

	localparam logic RST_LOCK = 1'b0;
	localparam logic [1:0] RST_BP = 2'h0;
	localparam logic RST_WEL = 1'b0;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [3:0] {
		ST_IGNORE,
		ST_DESEL,
		ST_OPCODE,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_MEM_RD,
		ST_MEM_WR,
		ST_STAT_RD,
		ST_STAT_WR
	} snm_state_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} snm_pins_t;

	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} snm_wr_t;

	typedef struct packed {
		snm_pins_t s1;
		snm_pins_t s2;
		logic sck_prev;
		snm_state_t state;
		logic is_read;
		logic [2:0] bitcnt;
		logic [7:0] shreg;
		logic [ADDR_W-1:0] addr;
		logic [7:0] tx;
		logic tx_on;
		logic so;
		logic so_oe;
		logic standby;
		logic wel;
		logic lock;
		logic [1:0] bp;
	} snm_regs_t;

endpackage

// file: core/snm_spi_slave.sv
// Overview of operation
// - Selected only while select is low
// - Deselected: inputs ignored, output floats, standby unless paused
// - New command only after select falling edge
// - Sample on clock rise, drive on fall
// - Any clock rate slow enough for clock_i to see each clock level, pauses allowed
// - Output driven only for read data
// - Pin plus lock bit block status writes
// - Pause freezes command, resume continues
// - Paused: clock and select edges ignored
// - Eight thousand one hundred ninety-two bytes
// - Byte written on its last bit
// - Clock modes zero and three only
// - Quarter, half or whole array protection
// - Write disable command blocks all writes
// - First byte after select is opcode
// - Two address bytes, low thirteen used
// - Everything shifted most significant bit first
// - Unknown opcode ignores rest of frame
`timescale 1ns/1ns
module snm_spi_slave (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire snm_pkg::snm_pins_t pins_i,
	output logic so_o,
	output logic so_oe_o,
	output logic standby_o
);

	snm_pkg::snm_regs_t r;
	snm_pkg::snm_regs_t nxt;
	snm_pkg::snm_wr_t wr;
	logic [snm_pkg::ADDR_W-1:0] rd_addr;
	logic [snm_pkg::DATA_W-1:0] rd_data;
	logic [7:0] rx;
	logic [7:0] status;
	logic paused;
	logic selected;
	logic rise;
	logic fall;
	logic byte_done;

	snm_array #(
		.DEPTH(snm_pkg::MEM_DEPTH)
	) u_array (
		.clock_i(clock_i),
		.wr_i(wr),
		.rd_addr_i(rd_addr),
		.rd_data_o(rd_data)
	);

	// Block protection of the upper part of the array
	function automatic logic is_protected(input logic [1:0] bp,
		input logic [snm_pkg::ADDR_W-1:0] a);
		logic p;
		p = 1'b0;
		case (bp)
			snm_pkg::BP_QUARTER: p = (a[snm_pkg::ADDR_W-1 -: 2] == 2'h3);
			snm_pkg::BP_HALF: p = a[snm_pkg::ADDR_W-1];
			snm_pkg::BP_ALL: p = 1'b1;
			default: p = 1'b0;
		endcase
		return p;
	endfunction

	assign paused = ~r.s2.hold_n;
	assign selected = ~r.s2.cs_n;
	// Only rising edges sample, so idle-low and idle-high clocks both work
	assign rise = r.s2.sck & ~r.sck_prev;
	assign fall = ~r.s2.sck & r.sck_prev;
	assign byte_done = (r.bitcnt == snm_pkg::LAST_BIT);
	assign rx = {r.shreg[6:0], r.s2.si};
	assign rd_addr = (r.state == snm_pkg::ST_ADDR_LO) ? {r.addr[12:8], rx} : r.addr;

	always_comb begin
		status = 8'h00;
		status[snm_pkg::STAT_LOCK_BIT] = r.lock;
		status[snm_pkg::STAT_BP_HI:snm_pkg::STAT_BP_LO] = r.bp;
		status[snm_pkg::STAT_WEL_BIT] = r.wel;
	end

	always_comb begin
		nxt = r;
		wr = '0;
		nxt.s1 = pins_i;
		nxt.s2 = r.s1;
		// Edge history follows the pin even while paused, so no stale edge on resume
		nxt.sck_prev = r.s2.sck;
		if (paused) begin
			// Nothing advances and select is not looked at
			nxt.state = r.state;
		end else if (!selected) begin
			nxt.state = snm_pkg::ST_DESEL;
			nxt.bitcnt = 3'h0;
			nxt.tx_on = 1'b0;
		end else if (r.state == snm_pkg::ST_DESEL) begin
			// Select just fell
			nxt.state = snm_pkg::ST_OPCODE;
			nxt.bitcnt = 3'h0;
		end else begin
			if (rise) begin
				nxt.shreg = rx;
				nxt.bitcnt = r.bitcnt + 3'h1;
			end
			if (rise && byte_done) begin
				case (r.state)
					snm_pkg::ST_OPCODE: begin
						nxt.is_read = 1'b0;
						if (rx == snm_pkg::OP_WRITE_ENABLE) begin
							nxt.wel = 1'b1;
							nxt.state = snm_pkg::ST_IGNORE;
						end else if (rx == snm_pkg::OP_WRITE_DISABLE) begin
							nxt.wel = 1'b0;
							nxt.state = snm_pkg::ST_IGNORE;
						end else if (rx == snm_pkg::OP_STATUS_READ) begin
							nxt.tx = status;
							nxt.state = snm_pkg::ST_STAT_RD;
						end else if (rx == snm_pkg::OP_STATUS_WRITE) begin
							nxt.state = snm_pkg::ST_STAT_WR;
						end else if (rx == snm_pkg::OP_MEM_READ) begin
							nxt.is_read = 1'b1;
							nxt.state = snm_pkg::ST_ADDR_HI;
						end else if (rx == snm_pkg::OP_MEM_WRITE) begin
							nxt.state = snm_pkg::ST_ADDR_HI;
						end else begin
							nxt.state = snm_pkg::ST_IGNORE;
						end
					end
					snm_pkg::ST_ADDR_HI: begin
						// Top three address bits are dropped
						nxt.addr[12:8] = rx[4:0];
						nxt.state = snm_pkg::ST_ADDR_LO;
					end
					snm_pkg::ST_ADDR_LO: begin
						if (r.is_read) begin
							nxt.tx = rd_data;
							nxt.addr = rd_addr + 13'h0001;
							nxt.state = snm_pkg::ST_MEM_RD;
						end else begin
							nxt.addr = rd_addr;
							nxt.state = snm_pkg::ST_MEM_WR;
						end
					end
					snm_pkg::ST_MEM_RD: begin
						// Sequential read wraps around the array
						nxt.tx = rd_data;
						nxt.addr = r.addr + 13'h0001;
					end
					snm_pkg::ST_MEM_WR: begin
						wr.en = r.wel & ~is_protected(r.bp, r.addr);
						wr.addr = r.addr;
						wr.data = rx;
						nxt.addr = r.addr + 13'h0001;
					end
					snm_pkg::ST_STAT_RD: begin
						nxt.tx = status;
					end
					snm_pkg::ST_STAT_WR: begin
						if (r.wel && !(r.lock && !r.s2.wp_n)) begin
							nxt.lock = rx[snm_pkg::STAT_LOCK_BIT];
							nxt.bp = rx[snm_pkg::STAT_BP_HI:snm_pkg::STAT_BP_LO];
						end
						nxt.state = snm_pkg::ST_IGNORE;
					end
					default: begin
						nxt.state = r.state;
					end
				endcase
			end
			if (fall && (r.state == snm_pkg::ST_MEM_RD || r.state == snm_pkg::ST_STAT_RD)) begin
				nxt.so = r.tx[7];
				nxt.tx = {r.tx[6:0], 1'b0};
				nxt.tx_on = 1'b1;
			end
		end
		// Output floats while paused, deselected or not in a read data phase
		nxt.so_oe = nxt.tx_on & ~paused & selected;
		nxt.standby = ~selected & ~paused;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r.s1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
			r.s2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
			r.sck_prev <= 1'b0;
			// Left for ST_DESEL on the first cycle, since the synchronizers reset select to high
			r.state <= snm_pkg::ST_IGNORE;
			r.is_read <= 1'b0;
			r.bitcnt <= 3'h0;
			r.shreg <= 8'h00;
			r.addr <= 13'h0000;
			r.tx <= 8'h00;
			r.tx_on <= 1'b0;
			r.so <= 1'b0;
			r.so_oe <= 1'b0;
			r.standby <= 1'b1;
			r.wel <= snm_pkg::RST_WEL;
			r.lock <= snm_pkg::RST_LOCK;
			r.bp <= snm_pkg::RST_BP;
		end else begin
			r <= nxt;
		end
	end

	assign so_o = r.so;
	assign so_oe_o = r.so_oe;
	assign standby_o = r.standby;

endmodule

// file: verif/snm_checker.sv
`timescale 1ns/1ns
module snm_checker (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire snm_pkg::snm_pins_t pins_i,
	input wire logic so_o,
	input wire logic so_oe_o,
	input wire logic standby_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	sequence desel;
		(pins_i.cs_n && pins_i.hold_n) [*6];
	endsequence
	sequence so_moves;
		so_oe_o && $past(so_oe_o) && $changed(so_o);
	endsequence
	chk_desel_quiet: assert property (desel |-> !so_oe_o)
		else $error("output driven while deselected");
	chk_desel_standby: assert property (desel |-> standby_o)
		else $error("standby low while deselected");
	chk_sel_awake: assert property (!pins_i.cs_n [*5] |-> !standby_o)
		else $error("standby high while selected");
	chk_hold_quiet: assert property (!pins_i.hold_n [*5] |-> !so_oe_o)
		else $error("output driven while paused");
	chk_so_on_fall: assert property (so_moves |-> !$past(pins_i.sck, 3))
		else $error("output moved after clock rise");
	chk_oe_on_fall: assert property ($rose(so_oe_o) |-> !$past(pins_i.sck, 3))
		else $error("output enabled after clock rise");
	chk_oe_drop: assert property ($rose(pins_i.cs_n) && pins_i.hold_n |-> ##[1:5] !so_oe_o)
		else $error("output still driven after deselect");
	chk_oe_not_idle: assert property (so_oe_o |-> !standby_o)
		else $error("output driven in standby");
	cover property ($rose(so_oe_o));
	cover property (!pins_i.hold_n && !pins_i.cs_n);
	cover property ($fell(standby_o));
endmodule
bind snm_spi_slave snm_checker snm_checker_inst (.clock_i(clock_i), .nrst_i(nrst_i),
	.pins_i(pins_i), .so_o(so_o), .so_oe_o(so_oe_o), .standby_o(standby_o));

// file: verif/snm_master.sv
`timescale 1ns/1ns
module snm_master (
	input wire logic clock_i,
	input wire logic so_i,
	input wire logic so_oe_i,
	output snm_pkg::snm_pins_t pins_o
);
	logic m3 = 1'b0;
	logic seen = 1'b0;
	initial pins_o = 5'b10011;
	task automatic w(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	// Mode 0 or 3 frame; a pause goes in before bit number pz
	task automatic frame(input logic [7:0] q[$], input int pz, output logic [7:0] r[$]);
		logic [7:0] b;
		r = {};
		pins_o.sck = m3;
		w(2);
		pins_o.cs_n = 1'b0;
		w(6);
		foreach (q[i]) begin
			for (int k = 7; k >= 0; k--) begin
				pins_o.sck = 1'b0;
				pins_o.si = q[i][k];
				w(6);
				if (i * 8 + 7 - k == pz) begin
					pins_o.hold_n = 1'b0;
					w(4);
					pins_o.sck = 1'b1;
					w(4);
					pins_o.sck = 1'b0;
					pins_o.cs_n = 1'b1;
					w(4);
					pins_o.cs_n = 1'b0;
					w(4);
					pins_o.hold_n = 1'b1;
					w(6);
				end
				// Released output reads as garbage
				b[k] = so_oe_i ? so_i : ~so_i;
				seen = seen | so_oe_i;
				pins_o.sck = 1'b1;
				w(4);
			end
			r.push_back(b);
		end
		pins_o.sck = m3;
		w(4);
		pins_o.cs_n = 1'b1;
		w(8);
	endtask
endmodule

// file: verif/snm_spi_slave_tb.sv
`timescale 1ns/1ns
module snm_spi_slave_tb;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic so_o;
	logic so_oe_o;
	logic standby_o;
	snm_pkg::snm_pins_t pins;
	logic [7:0] r[$];
	int err_count = 0;
	int check_count = 0;
	always #25 clock_i = ~clock_i;
	snm_master snm_master_inst (.clock_i(clock_i), .so_i(so_o), .so_oe_i(so_oe_o),
		.pins_o(pins));
	snm_spi_slave snm_spi_slave_inst (.clock_i(clock_i), .nrst_i(nrst_i), .pins_i(pins),
		.so_o(so_o), .so_oe_o(so_oe_o), .standby_o(standby_o));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic go(input logic [7:0] q[$], input int pz = 99);
		snm_master_inst.frame(q, pz, r);
	endtask
	task automatic wen;
		go('{snm_pkg::OP_WRITE_ENABLE});
	endtask
	task automatic ws(input logic [7:0] v);
		wen();
		go('{snm_pkg::OP_STATUS_WRITE, v});
	endtask
	task automatic st(input logic [7:0] e);
		go('{snm_pkg::OP_STATUS_READ, 8'h00});
		chk("status", r[1], e);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		go('{snm_pkg::OP_MEM_WRITE, a[15:8], a[7:0], d});
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		go('{snm_pkg::OP_MEM_READ, a[15:8], a[7:0], 8'h00});
		chk("mem", r[3], e);
	endtask
	task automatic t_rw(input logic m, input logic [7:0] d);
		snm_master_inst.m3 = m;
		wen();
		snm_master_inst.seen = 1'b0;
		go('{snm_pkg::OP_MEM_WRITE, 8'hff, 8'hff, d, ~d});
		chk("oe", snm_master_inst.seen, 0);
		go('{snm_pkg::OP_MEM_READ, 8'h1f, 8'hff, 8'h00, 8'h00});
		chk("top", r[3], d);
		chk("wrap", r[4], ~d);
	endtask
	task automatic t_bp;
		logic [15:0] a[3] = '{16'h1800, 16'h1000, 16'h0000};
		foreach (a[i]) wr(a[i], 8'h00);
		for (int k = 1; k < 4; k++) begin
			ws({4'h0, 2'(k), 2'h0});
			st({4'h0, 2'(k), 2'h2});
			wr(a[k - 1], 8'hff);
			rd(a[k - 1], 8'h00);
		end
		ws(8'h00);
	endtask
	task automatic t_wd;
		wr(16'h0010, 8'h5a);
		go('{snm_pkg::OP_WRITE_DISABLE});
		wr(16'h0010, 8'ha5);
		rd(16'h0010, 8'h5a);
		go('{snm_pkg::OP_STATUS_WRITE, 8'h0c});
		st(8'h00);
	endtask
	task automatic t_lock;
		ws(8'h80);
		snm_master_inst.pins_o.wp_n = 1'b0;
		ws(8'h0c);
		st(8'h82);
		snm_master_inst.pins_o.wp_n = 1'b1;
		ws(8'h00);
		st(8'h02);
	endtask
	task automatic t_hold;
		wr(16'h0123, 8'hc3);
		go('{snm_pkg::OP_MEM_READ, 8'h01, 8'h23, 8'h00}, 27);
		chk("paused", r[3], 8'hc3);
	endtask
	task automatic t_bad;
		snm_master_inst.seen = 1'b0;
		go('{8'hff, snm_pkg::OP_MEM_READ, 8'h01, 8'h23});
		chk("oe", snm_master_inst.seen, 0);
		go('{snm_pkg::OP_MEM_READ, 8'h01});
		st(8'h02);
	endtask
	initial begin
		repeat (90000) @(posedge clock_i);
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (5) @(negedge clock_i);
		nrst_i = 1'b1;
		repeat (8) @(negedge clock_i);
		chk("standby", standby_o, 1);
		t_rw(1'b0, 8'h96);
		t_rw(1'b1, 8'h3c);
		snm_master_inst.m3 = 1'b0;
		t_bp();
		t_wd();
		t_lock();
		t_hold();
		t_bad();
		wrap_up();
	end
endmodule
